// [hw/global_config_pkg.sv]
// Purpose: constants for the global configuration register block
// Assumes: one 17-bit register at offset 0x00 on the serial register port
// Notes:   address, width, bit positions, reset value, index position and sync stages
package global_config_pkg;

	localparam int          cfg_width        = 17;
	localparam logic [6:0]  global_cfg_addr  = 7'h00;
	localparam logic [16:0] global_cfg_reset = 17'h00000;

	// field positions
	localparam int bit_analog_ref      = 0;
	localparam int bit_internal_sense  = 1;
	localparam int bit_quiet_pwm       = 2;
	localparam int bit_enc_commutation = 3;
	localparam int bit_invert_dir      = 4;
	localparam int bit_a_fault         = 5;
	localparam int bit_a_prewarn       = 6;
	localparam int bit_a_stall_step    = 7;
	localparam int bit_b_stall_dir     = 8;
	localparam int bit_b_index         = 9;
	localparam int bit_b_chopper_on    = 10;
	localparam int bit_b_skip_toggle   = 11;
	localparam int bit_a_pushpull      = 12;
	localparam int bit_b_pushpull      = 13;

	localparam logic [7:0] index_position = 8'h00;
	localparam int         sync_stages    = 3;

endpackage

// [hw/global_config_register.sv]
// Purpose: global configuration register and diagnostic pin routing
// Assumes: register port write/read strobes come from the serial interface on ref_clk
// Notes:   external_step_mode_select arrives from a pin and is synchronised
`timescale 1ns/10ps

// What this block does
// - bit 0 selects analog input current reference
// - bit 1 selects internal sense resistors
// - bit 2 enables quiet pwm; standstill only
// - bit 4 inverts motor direction
// - mode high, bit 5: pin a on faults
// - pin a active during reset
// - mode high, bit 6: pin a on prewarning
// - mode high, bit 7: pin a on stall
// - mode low: pin a interrupt or step
// - mode high, bit 8: pin b on stall
// - mode low: pin b compare or direction
// - mode high, bit 9: pin b at index
// - mode high, bit 10: pin b chopper on
// - mode high, bit 11: pin b toggles on skip
// - register clears to zero at reset
// - pin a open collector active low default
module global_config_register (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_write,
	input  wire logic [16:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// configuration to the core
	output logic             analog_reference_sel,
	output logic             internal_sense_sel,
	output logic             quiet_pwm_enable,
	output logic             encoder_commutation,
	output logic             invert_direction,
	// event sources
	input  wire logic        external_step_mode_select,
	input  wire logic        overtemperature,
	input  wire logic        short_to_ground,
	input  wire logic        prewarning,
	input  wire logic        stall,
	input  wire logic        interrupt_req,
	input  wire logic        step_toggle,
	input  wire logic        motor_direction,
	input  wire logic        position_compare,
	input  wire logic        standstill,
	input  wire logic [7:0]  microstep_position,
	input  wire logic        chopper_on_second_half,
	input  wire logic        lost_step_inc,
	// diagnostic pins
	output logic             event_pin_a_pad_o,
	output logic             event_pin_a_pad_oe,
	output logic             event_pin_b_o,
	output logic             event_pin_b_oe
);

	// ****************
	// register
	// ****************
	logic [16:0] cfg_q;
	logic [16:0] cfg_d;

	always_comb begin
		cfg_d = reg_wdata;
		// off to on of quiet pwm only at standstill
		if (!cfg_q[global_config_pkg::bit_quiet_pwm] && !standstill) begin
			cfg_d[global_config_pkg::bit_quiet_pwm] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_q <= global_config_pkg::global_cfg_reset;
		end else if (reg_write && reg_addr == global_config_pkg::global_cfg_addr) begin
			cfg_q <= cfg_d;
		end
	end

	always_comb begin
		reg_rdata = 32'h00000000;
		if (reg_addr == global_config_pkg::global_cfg_addr) begin
			reg_rdata[16:0] = cfg_q;
		end
	end

	assign analog_reference_sel = cfg_q[global_config_pkg::bit_analog_ref];
	assign internal_sense_sel   = cfg_q[global_config_pkg::bit_internal_sense];
	assign quiet_pwm_enable     = cfg_q[global_config_pkg::bit_quiet_pwm];
	assign encoder_commutation  = cfg_q[global_config_pkg::bit_enc_commutation];
	assign invert_direction     = cfg_q[global_config_pkg::bit_invert_dir];

	// ****************
	// mode pin sync
	// ****************
	logic [2:0] mode_sync_q;
	logic       mode_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_sync_q <= 3'h0;
		end else begin
			mode_sync_q <= {mode_sync_q[1:0], external_step_mode_select};
		end
	end

	// a level counts only once both late stages agree; a short glitch is dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q <= 1'b0;
		end else if (mode_sync_q[1] == mode_sync_q[2]) begin
			mode_q <= mode_sync_q[2];
		end
	end

	// ****************
	// skip toggle
	// ****************
	// toggles even while bit 11 is clear; only the pin view is gated
	logic skip_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			skip_q <= 1'b0;
		end else if (lost_step_inc) begin
			skip_q <= ~skip_q;
		end
	end

	// ****************
	// pin a routing
	// ****************
	logic a_act_d;
	logic a_act_q;

	always_comb begin
		a_act_d = 1'b0;
		if (mode_q) begin
			if (cfg_q[global_config_pkg::bit_a_fault]
			    && (overtemperature || short_to_ground)) begin
				a_act_d = 1'b1;
			end
			if (cfg_q[global_config_pkg::bit_a_prewarn] && prewarning) begin
				a_act_d = 1'b1;
			end
			if (cfg_q[global_config_pkg::bit_a_stall_step] && stall) begin
				a_act_d = 1'b1;
			end
		end else begin
			// step level passes through; the external driver steps on both edges
			a_act_d = cfg_q[global_config_pkg::bit_a_stall_step]
			          ? step_toggle : interrupt_req;
		end
	end

	// active in reset whatever the configuration says
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			a_act_q <= 1'b1;
		end else begin
			a_act_q <= a_act_d;
		end
	end

	// ****************
	// pin b routing
	// ****************
	logic b_act_d;
	logic b_act_q;

	always_comb begin
		b_act_d = 1'b0;
		if (mode_q) begin
			if (cfg_q[global_config_pkg::bit_b_stall_dir] && stall) begin
				b_act_d = 1'b1;
			end
			if (cfg_q[global_config_pkg::bit_b_index]
			    && microstep_position == global_config_pkg::index_position) begin
				b_act_d = 1'b1;
			end
			if (cfg_q[global_config_pkg::bit_b_chopper_on] && chopper_on_second_half) begin
				b_act_d = 1'b1;
			end
			if (cfg_q[global_config_pkg::bit_b_skip_toggle] && skip_q) begin
				b_act_d = 1'b1;
			end
		end else begin
			b_act_d = cfg_q[global_config_pkg::bit_b_stall_dir]
			          ? motor_direction : position_compare;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			b_act_q <= 1'b0;
		end else begin
			b_act_q <= b_act_d;
		end
	end

	// ****************
	// pad drive
	// ****************
	// open collector pulls low when active; push-pull drives high when active
	always_comb begin
		if (cfg_q[global_config_pkg::bit_a_pushpull]) begin
			event_pin_a_pad_o  = a_act_q;
			event_pin_a_pad_oe = 1'b1;
		end else begin
			event_pin_a_pad_o  = 1'b0;
			event_pin_a_pad_oe = a_act_q;
		end
	end

	always_comb begin
		if (cfg_q[global_config_pkg::bit_b_pushpull]) begin
			event_pin_b_o  = b_act_q;
			event_pin_b_oe = 1'b1;
		end else begin
			event_pin_b_o  = 1'b0;
			event_pin_b_oe = b_act_q;
		end
	end

endmodule

// [verif/global_config_register_sva.sv]
// Purpose: port assertions for the configuration block
// Assumes: one clock, rst_n synchronous low
// Notes:   bound into every instance
`timescale 1ns/10ps
module global_config_register_sva (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [6:0]  reg_addr,
	input wire logic        reg_write,
	input wire logic [16:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        analog_reference_sel,
	input wire logic        internal_sense_sel,
	input wire logic        quiet_pwm_enable,
	input wire logic        encoder_commutation,
	input wire logic        invert_direction,
	input wire logic        standstill,
	input wire logic        event_pin_a_pad_o,
	input wire logic        event_pin_a_pad_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr; reg_write && reg_addr == 7'h00; endsequence
	property p_ref; s_wr |=> analog_reference_sel == $past(reg_wdata[0]); endproperty
	a_ref: assert property (p_ref) else $error("ref select");
	property p_sns; s_wr |=> internal_sense_sel == $past(reg_wdata[1]); endproperty
	a_sns: assert property (p_sns) else $error("sense select");
	property p_hold; s_wr ##0 !standstill && !quiet_pwm_enable |=> !quiet_pwm_enable; endproperty
	a_hold: assert property (p_hold) else $error("pwm on in motion");
	property p_pwm; s_wr ##0 standstill |=> quiet_pwm_enable == $past(reg_wdata[2]); endproperty
	a_pwm: assert property (p_pwm) else $error("pwm bit");
	property p_enc; s_wr |=> encoder_commutation == $past(reg_wdata[3]); endproperty
	a_enc: assert property (p_enc) else $error("encoder bit");
	property p_dir; s_wr |=> invert_direction == $past(reg_wdata[4]); endproperty
	a_dir: assert property (p_dir) else $error("direction bit");
	property p_rst; disable iff (1'b0) !rst_n |=> event_pin_a_pad_oe && !event_pin_a_pad_o; endproperty
	a_rst: assert property (p_rst) else $error("pin a in reset");
	property p_clr; disable iff (1'b0) !rst_n |=> reg_addr != 7'h00 || reg_rdata == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("register not clear");
endmodule

bind global_config_register global_config_register_sva i_global_config_register_sva (.*);

// [verif/cfg_host.sv]
// Purpose: host model issuing register writes
// Assumes: go sampled on the rising edge
// Notes:   write strobe lasts one cycle
`timescale 1ns/10ps
module cfg_host (
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic [16:0] cfg,
	output logic             reg_write,
	output logic      [16:0] reg_wdata
);
	initial begin
		reg_write = 1'b0;
		reg_wdata = 17'h00000;
	end
	always @(posedge ref_clk) begin
		reg_write <= go;
		reg_wdata <= go ? cfg & (cfg[11] ? ~17'h00708 : ~17'h00008) : ~reg_wdata;
	end
endmodule

// [verif/global_config_register_tb.sv]
// Purpose: self-checking bench for the configuration block
// Assumes: inputs change on the falling edge
// Notes:   pins run push-pull except in reset, t_cfg and t_oc, which checks open collector
`timescale 1ns/10ps
module global_config_register_tb;
	logic        ref_clk = 0;
	logic        rst_n = 0;
	logic        go = 0;
	logic [16:0] cfg = 0;
	logic [6:0]  addr = 0;
	logic        mode = 1;
	logic        still = 0;
	logic [9:0]  ev = 0;
	logic [7:0]  pos = 8'h01;
	logic        wr, a_o, a_oe, b_o, b_oe;
	logic [16:0] wd;
	logic [31:0] rd;
	logic [4:0]  cf;
	int          n_errors = 0;
	int          checks_done = 0;
	initial forever #20 ref_clk = ~ref_clk;
	cfg_host i_cfg_host (.ref_clk(ref_clk), .go(go), .cfg(cfg), .reg_write(wr), .reg_wdata(wd));
	global_config_register i_global_config_register (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(addr), .reg_write(wr), .reg_wdata(wd), .reg_rdata(rd),
		.analog_reference_sel(cf[0]), .internal_sense_sel(cf[1]), .quiet_pwm_enable(cf[2]),
		.encoder_commutation(cf[3]), .invert_direction(cf[4]), .external_step_mode_select(mode),
		.overtemperature(ev[9]), .short_to_ground(ev[8]), .prewarning(ev[7]), .stall(ev[6]),
		.interrupt_req(ev[5]), .step_toggle(ev[4]), .motor_direction(ev[3]),
		.position_compare(ev[2]), .standstill(still), .microstep_position(pos),
		.chopper_on_second_half(ev[1]), .lost_step_inc(ev[0]), .event_pin_a_pad_o(a_o),
		.event_pin_a_pad_oe(a_oe), .event_pin_b_o(b_o), .event_pin_b_oe(b_oe));
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			$display("[FAIL] %s exp %h got %h", nm, x, g);
			n_errors++;
		end
	endtask
	task automatic wrt(input logic [16:0] c);
		cfg = c;
		go = 1;
		@(negedge ref_clk) go = 0;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic pin(input logic [16:0] c, input logic m, input logic [9:0] e,
		input logic [1:0] x);
		mode = m;
		ev = e;
		wrt(c | 17'h03000);
		repeat (4) @(negedge ref_clk);
		chk("pins a b", {28'h0, 2'b11, x}, {28'h0, a_oe, b_oe, a_o, b_o});
	endtask
	task automatic t_cfg;
		wrt(17'h00017);
		chk("cfg moving", 32'h13, {27'h0, cf});
		still = 1;
		wrt(17'h0001f);
		chk("cfg still", 32'h17, {27'h0, cf});
		addr = 7'h01;
		wrt(17'h00000);
		chk("unmapped read", 32'h0, rd);
		addr = 7'h00;
		chk("cfg kept", 32'h17, {27'h0, cf});
	endtask
	task automatic t_skip;
		pin(17'h00800, 1, 10'h000, 2'b00);
		for (int i = 1; i <= 2; i++) begin
			ev[0] = 1;
			@(negedge ref_clk) ev[0] = 0;
			repeat (2) @(negedge ref_clk);
			chk("skip toggle", {31'h0, i[0]}, {31'h0, b_o});
		end
	endtask
	task automatic t_a;
		pin(17'h00020, 1, 10'h200, 2'b10);
		pin(17'h00020, 1, 10'h100, 2'b10);
		pin(17'h00040, 1, 10'h080, 2'b10);
		pin(17'h00080, 1, 10'h040, 2'b10);
		pin(17'h00020, 1, 10'h0c0, 2'b00);
	endtask
	task automatic t_b;
		pin(17'h00100, 1, 10'h040, 2'b01);
		pos = 8'h00;
		pin(17'h00200, 1, 10'h000, 2'b01);
		pos = 8'h01;
		pin(17'h00200, 1, 10'h000, 2'b00);
		pin(17'h00400, 1, 10'h002, 2'b01);
	endtask
	task automatic t_low;
		pin(17'h00080, 0, 10'h010, 2'b10);
		pin(17'h00000, 0, 10'h020, 2'b10);
		pin(17'h00000, 0, 10'h010, 2'b00);
		pin(17'h00100, 0, 10'h008, 2'b01);
		pin(17'h00000, 0, 10'h004, 2'b01);
		pin(17'h00100, 0, 10'h004, 2'b00);
	endtask
	task automatic t_oc;
		ev = 10'h024;
		wrt(17'h00000);
		chk("open collector on", 32'ha, {28'h0, a_oe, a_o, b_oe, b_o});
		ev = 10'h000;
		repeat (2) @(negedge ref_clk);
		chk("open collector off", 32'h0, {28'h0, a_oe, a_o, b_oe, b_o});
	endtask
	task automatic t_rst;
		wrt(17'h03017);
		rst_n = 0;
		repeat (2) @(negedge ref_clk);
		chk("pins mid reset", 32'h8, {28'h0, a_oe, a_o, b_oe, b_o});
		chk("reset clears", 32'h0, rd);
		rst_n = 1;
		@(negedge ref_clk);
		chk("cfg after reset", 32'h0, {27'h0, cf});
		chk("pins after reset", 32'h0, {28'h0, a_oe, a_o, b_oe, b_o});
	endtask
	task automatic stop_test;
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		chk("pin a reset", 32'h2, {30'h0, a_oe, a_o});
		rst_n = 1;
		@(negedge ref_clk);
		chk("reset value", 32'h0, rd);
		t_cfg();
		t_skip();
		t_a();
		t_b();
		t_low();
		t_oc();
		t_rst();
		stop_test();
	end
endmodule
